/* testbench/tpu_pin_partner.sv */
/* far side of the channel pins: resolves each pin from the timer enable and an
   outside level, and times the high and low runs on every pin.
   assumes the bench sets ext_level and reads the run lengths. */
`timescale 1ns/100ps
`default_nettype none

module tpu_pin_partner #(
   parameter int NCH = 2
) (
   input  wire logic           clk,
   input  wire logic [NCH-1:0] ext_level,
   input  wire logic [NCH-1:0] ch_pin_out,
   input  wire logic [NCH-1:0] ch_pin_oe_n,
   output logic      [NCH-1:0] pin_wire,
   output logic      [15:0]    high_len [NCH],
   output logic      [15:0]    low_len  [NCH]
);
   logic [NCH-1:0] prev_q;
   logic [15:0]    run_q [NCH];
   // outside source backs off while the timer drives the pin
   assign pin_wire = (ch_pin_oe_n & ext_level) | (~ch_pin_oe_n & ch_pin_out);

   always_ff @(posedge clk) begin
      prev_q <= pin_wire;
      for (int i = 0; i < NCH; i++) begin
         if (pin_wire[i] != prev_q[i]) begin
            if (prev_q[i]) begin
               high_len[i] <= run_q[i];
            end else begin
               low_len[i] <= run_q[i];
            end
            run_q[i] <= 16'h0001;
         end else begin
            run_q[i] <= run_q[i] + 16'h0001;
         end
      end
   end
endmodule : tpu_pin_partner

`default_nettype wire

/* testbench/tpu_timer_bench.sv */
/* self-checking bench for the timer pwm unit: counter flags, center pwm,
   buffered loads, capture and compare channels.
   assumes the pin partner model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none

module tpu_timer_bench;
   localparam logic [7:0] TSC  = tpu_pkg::TSC_ADDR;
   localparam logic [7:0] MODH = tpu_pkg::MODH_ADDR;
   localparam logic [7:0] C0SC = tpu_pkg::CH_BASE;
   localparam logic [7:0] C0H  = C0SC + 8'h01;
   localparam logic [7:0] C1SC = C0SC + tpu_pkg::CH_STRIDE;
   localparam logic [7:0] C1H  = C1SC + 8'h01;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [1:0]  ext_level = 2'b00;
   logic [7:0]  rdata, d, sc;
   logic [1:0]  pin_wire, pin_out, pin_oe_n, ch_irq;
   logic        ovf_irq;
   logic [15:0] high_len [2];
   logic [15:0] low_len [2];
   int          bad_count = 0;
   int          tests_run = 0;

   always #4 clk = ~clk;

   tpu_timer #(.NCH(2)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ch_pin_in(pin_wire), .ch_pin_out(pin_out), .ch_pin_oe_n(pin_oe_n),
      .overflow_irq(ovf_irq), .channel_irq(ch_irq));
   tpu_pin_partner #(.NCH(2)) partner (.clk(clk), .ext_level(ext_level), .ch_pin_out(pin_out),
      .ch_pin_oe_n(pin_oe_n), .pin_wire(pin_wire), .high_len(high_len), .low_len(low_len));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   // high byte first, then the low byte one address up
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr_reg(a, v[15:8]);
      wr_reg(a + 8'h01, v[7:0]);
   endtask : wr16

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge clk);
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
      logic [7:0] v;
      rd_reg(a, v);
      check(name, v, exp);
   endtask : rd_chk

   task automatic steady(input logic lvl, input string name);
      int n;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (pin_wire[0] !== lvl) n++;
      end
      check(name, n[15:0], 16'h0000);
   endtask : steady

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(TSC, 8'h00, "tsc at reset");
      rd_chk(MODH + 8'h01, 8'h00, "modulus at reset");
      rd_chk(C1SC, 8'h00, "channel control at reset");
      rd_chk(8'hF0, 8'h00, "unmapped byte");
      $display("test reset done");
      wr_reg(TSC, 8'h48);
      repeat (65500) @(posedge clk);
      rd_chk(TSC, 8'h48, "flag before full wrap");
      repeat (60) @(posedge clk);
      rd_chk(TSC, 8'hC8, "flag after full wrap");
      check("overflow irq", ovf_irq, 1'b1);
      wr_reg(TSC, 8'h48);
      rd_chk(TSC, 8'h48, "flag after clear");
      check("overflow irq cleared", ovf_irq, 1'b0);
      // slow prescale so events land only where intended
      wr_reg(TSC, 8'h4F);
      wr16(MODH, 16'h0004);
      wr_reg(tpu_pkg::CNTH_ADDR, 8'h00);
      repeat (700) @(posedge clk);
      rd_chk(TSC, 8'hCF, "flag at modulus wrap");
      repeat (700) @(posedge clk);
      wr_reg(TSC, 8'h4F);
      rd_chk(TSC, 8'hCF, "flag kept after late event");
      $display("test counter flags done");
      wr_reg(TSC, 8'h00);
      wr_reg(C0SC, 8'h08);
      wr16(C0H, 16'h0003);
      wr_reg(C1SC, 8'h04);
      wr16(C1H, 16'h0003);
      wr16(MODH, 16'h000A);
      wr_reg(tpu_pkg::CNTH_ADDR, 8'h00);
      wr_reg(TSC, 8'h28);
      repeat (60) @(posedge clk);
      check("ch0 high run", high_len[0], 16'h0006);
      check("ch0 low run", low_len[0], 16'h000E);
      check("ch1 high run", high_len[1], 16'h000E);
      rd_chk(C0SC, 8'h88, "center channel flag");
      rd_chk(TSC, 8'hA8, "reversal flag");
      wr_reg(TSC, 8'h20);
      wr16(C0H, 16'h0005);
      wr16(C1H, 16'h0005);
      rd_chk(C0H + 8'h01, 8'h03, "value held in buffer");
      wr_reg(TSC, 8'h28);
      repeat (60) @(posedge clk);
      rd_chk(C0H + 8'h01, 8'h05, "ch0 value after reversal");
      rd_chk(C1H + 8'h01, 8'h05, "ch1 value after reversal");
      check("ch0 wider high run", high_len[0], 16'h000A);
      wr_reg(MODH, 8'h00);
      wr_reg(TSC, 8'h28);
      wr_reg(MODH + 8'h01, 8'h08);
      wr_reg(C0H, 8'h00);
      wr_reg(C0SC, 8'h08);
      wr_reg(C0H + 8'h01, 8'h01);
      repeat (60) @(posedge clk);
      rd_chk(MODH + 8'h01, 8'h0A, "modulus pair broken");
      rd_chk(C0H + 8'h01, 8'h05, "value pair broken");
      // drop the lone channel 0 value low byte left pending above
      wr_reg(C0SC, 8'h08);
      wr16(C0H, 16'h8000);
      repeat (50) @(posedge clk);
      steady(1'b0, "negative value duty");
      wr16(C0H, 16'h0020);
      repeat (50) @(posedge clk);
      steady(1'b1, "value above modulus duty");
      $display("test center pwm done");
      wr_reg(TSC, 8'h08);
      repeat (8) @(posedge clk);
      for (int e = 0; e < 4; e++) begin
         sc = {4'h4, e[1:0], 2'b00};
         rd_reg(C0SC, d);
         wr_reg(C0SC, sc);
         ext_level[0] <= 1'b1;
         repeat (6) @(posedge clk);
         rd_chk(C0SC, {e == 1 || e == 3, sc[6:0]}, "rising edge capture");
         check("channel irq level", ch_irq[0], e == 1 || e == 3);
         rd_reg(C0SC, d);
         wr_reg(C0SC, sc);
         ext_level[0] <= 1'b0;
         repeat (6) @(posedge clk);
         rd_chk(C0SC, {e >= 2, sc[6:0]}, "falling edge capture");
      end
      wr_reg(TSC, 8'h0F);
      wr_reg(C1SC, 8'h50);
      wr16(C1H, 16'h0007);
      rd_chk(C1H + 8'h01, 8'h07, "compare value loaded");
      wr_reg(tpu_pkg::CNTH_ADDR, 8'h00);
      // eighth slow tick may land up to 1024 clocks after the counter reset
      repeat (1100) @(posedge clk);
      rd_chk(C1SC, 8'hD0, "compare match flag");
      check("channel 1 irq level", ch_irq[1], 1'b1);
      wr_reg(C1SC, 8'h50);
      rd_chk(C1SC, 8'h50, "compare flag cleared");
      // counter stopped, so no match can set the flag before edge pwm starts
      wr_reg(TSC, 8'h00);
      wr_reg(C1SC, 8'h20);
      rd_chk(C1SC, 8'h20, "edge pwm flag idle");
      wr_reg(TSC, 8'h08);
      repeat (30) @(posedge clk);
      rd_chk(C1SC, 8'hA0, "edge pwm match flag");
      $display("test channels done");
      wrap_up();
   end

   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule : tpu_timer_bench

`default_nettype wire

/* testbench/tpu_timer_monitor.sv */
/* port checker for the timer pwm unit: irq gating, flag clearing, released capture pins.
   assumes one clock, synchronous active-high reset and at least two channels. */
`timescale 1ns/100ps
`default_nettype none

module tpu_timer_monitor #(
   parameter int NCH = 2
) (
   input wire logic           clk,
   input wire logic           rst,
   input wire logic [7:0]     addr,
   input wire logic [7:0]     wdata,
   input wire logic           wr,
   input wire logic           rd,
   input wire logic [7:0]     rdata,
   input wire logic [NCH-1:0] ch_pin_in,
   input wire logic [NCH-1:0] ch_pin_out,
   input wire logic [NCH-1:0] ch_pin_oe_n,
   input wire logic           overflow_irq,
   input wire logic [NCH-1:0] channel_irq
);
   logic tsc_wr, sc0_wr, sc1_wr, ovf_clr, c0_clr, c1_clr, cap0, cap1;
   logic ovf_en_q, en0_q, en1_q, center_q, mode0_q, mode1_q;
   assign tsc_wr  = wr && addr == tpu_pkg::TSC_ADDR;
   assign sc0_wr  = wr && addr == tpu_pkg::CH_BASE;
   assign sc1_wr  = wr && addr == tpu_pkg::CH_BASE + tpu_pkg::CH_STRIDE;
   assign ovf_clr = tsc_wr && !wdata[7];
   assign c0_clr  = sc0_wr && !wdata[7];
   assign c1_clr  = sc1_wr && !wdata[7];
   assign cap0    = !center_q && mode0_q;
   assign cap1    = !center_q && mode1_q;

   // shadow of enables and modes, taken from the write port only
   always_ff @(posedge clk) begin
      if (rst) begin
         {ovf_en_q, en0_q, en1_q, center_q} <= 4'h0;
         {mode0_q, mode1_q} <= 2'b11;
      end else begin
         if (tsc_wr) begin
            {ovf_en_q, center_q} <= {wdata[6], wdata[5]};
         end
         if (sc0_wr) begin
            {en0_q, mode0_q} <= {wdata[6], wdata[5:4] == 2'b00};
         end
         if (sc1_wr) begin
            {en1_q, mode1_q} <= {wdata[6], wdata[5:4] == 2'b00};
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_ovf_irq_gated: assert property (overflow_irq |-> $past(ovf_en_q))
      else $error("overflow irq raised with its enable off");
   a_ch0_irq_gated: assert property (channel_irq[0] |-> $past(en0_q))
      else $error("channel 0 irq raised with its enable off");
   a_ch1_irq_gated: assert property (channel_irq[1] |-> $past(en1_q))
      else $error("channel 1 irq raised with its enable off");
   // a flag drop shows two cycles after its clearing write
   a_ovf_clear_seq: assert property (
      $fell(overflow_irq) && $past(ovf_en_q) && !$past(rst) |-> $past(ovf_clr, 2))
      else $error("overflow flag dropped without a zero write");
   a_ch0_clear_seq: assert property (
      $fell(channel_irq[0]) && $past(en0_q) && !$past(rst) |-> $past(c0_clr, 2))
      else $error("channel 0 flag dropped without a zero write");
   a_ch1_clear_seq: assert property (
      $fell(channel_irq[1]) && $past(en1_q) && !$past(rst) |-> $past(c1_clr, 2))
      else $error("channel 1 flag dropped without a zero write");
   a_cap0_released: assert property (cap0 && $past(cap0) |-> ch_pin_oe_n[0])
      else $error("capture pin 0 driven by the timer");
   a_cap1_released: assert property (cap1 && $past(cap1) |-> ch_pin_oe_n[1])
      else $error("capture pin 1 driven by the timer");

   c_ovf_irq: cover property ($rose(overflow_irq));
   c_ch0_irq: cover property ($rose(channel_irq[0]));
   c_ovf_clear: cover property ($fell(overflow_irq));
endmodule : tpu_timer_monitor

bind tpu_timer tpu_timer_monitor #(.NCH(NCH)) u_monitor (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out), .ch_pin_oe_n(ch_pin_oe_n),
   .overflow_irq(overflow_irq), .channel_irq(channel_irq));

`default_nettype wire

/* verilog/tpu_pkg.sv */
/*
 * shared constants and carrier types for the timer pwm unit:
 * byte register offsets, control field layouts, reset values, modes.
 * assumes an 8-bit register port with one byte per offset.
 */
`default_nettype none

package tpu_pkg;

   localparam int          DATA_W       = 8;
   localparam int          CNT_W        = 16;
   localparam int          PS_W         = 3;

   // byte offsets on the register port
   localparam logic [7:0]  TSC_ADDR     = 8'h00;
   localparam logic [7:0]  CNTH_ADDR    = 8'h01;
   localparam logic [7:0]  CNTL_ADDR    = 8'h02;
   localparam logic [7:0]  MODH_ADDR    = 8'h03;
   localparam logic [7:0]  MODL_ADDR    = 8'h04;
   localparam logic [7:0]  CH_BASE      = 8'h05;
   localparam logic [7:0]  CH_STRIDE    = 8'h03;
   localparam logic [7:0]  CH_SC_OFS    = 8'h00;
   localparam logic [7:0]  CH_VH_OFS    = 8'h01;
   localparam logic [7:0]  CH_VL_OFS    = 8'h02;

   // reset values and the full-range count
   localparam logic [7:0]  TSC_RESET    = 8'h00;
   localparam logic [7:0]  CHSC_RESET   = 8'h00;
   localparam logic [15:0] MOD_RESET    = 16'h0000;
   localparam logic [15:0] CV_RESET     = 16'h0000;
   localparam logic [15:0] CNT_FULL     = 16'hFFFF;
   localparam logic [7:0]  RD_IDLE      = 8'h00;

   // timer status and control: flag, irq enable, center select, spare, run, prescale
   typedef struct packed {
      logic              overflow_flag;
      logic              overflow_irq_enable;
      logic              center_align_select;
      logic              spare;
      logic              run;
      logic [PS_W-1:0]   prescale;
   } tpu_tsc_t;

   // channel status and control
   typedef struct packed {
      logic              channel_event_flag;
      logic              channel_irq_enable;
      logic              mode_high_bit;
      logic              mode_low_bit;
      logic              edge_level_select_high_bit;
      logic              edge_level_select_low_bit;
      logic [1:0]        spare;
   } tpu_chsc_t;

   typedef enum logic {TPU_UP, TPU_DOWN} tpu_dir_t;

   typedef enum logic [1:0] {TPU_CAPTURE, TPU_COMPARE, TPU_EDGE_PWM, TPU_CENTER_PWM} tpu_chmode_t;

endpackage : tpu_pkg

`default_nettype wire

/* verilog/tpu_timer.sv */
/*
 * 16-bit timer with up or up/down counting, byte-buffered modulus and
 * channel values, capture / compare / edge pwm / center pwm channels,
 * and read-then-write-zero flag clearing.
 * assumes a same-clock 8-bit register port (read data one cycle later)
 * and asynchronous channel pins, synchronised here.
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module tpu_timer #(
   parameter int NCH = 2
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [7:0]           rdata,
   input  wire logic [NCH-1:0]       ch_pin_in,
   output logic      [NCH-1:0]       ch_pin_out,
   output logic      [NCH-1:0]       ch_pin_oe_n,
   output logic                      overflow_irq,
   output logic      [NCH-1:0]       channel_irq
);

   // set wins over clear
   function automatic logic flag_upd(input logic flag, input logic arm, input logic set_ev, input logic clr_wr);
      return set_ev | (flag & ~(clr_wr & arm));
   endfunction : flag_upd

   // arm tracks the read-while-set step; any event restarts the sequence
   function automatic logic arm_upd(input logic flag, input logic arm, input logic set_ev,
                                    input logic rd_hit, input logic wr_hit);
      if (set_ev)
         return 1'b0;
      else if (rd_hit && flag)
         return 1'b1;
      else if (wr_hit)
         return 1'b0;
      return arm;
   endfunction : arm_upd

   tpu_pkg::tpu_tsc_t  tsc_reg;
   logic               tof_reg;
   logic               tof_arm_reg;
   logic               irq_reg;
   logic [15:0]        cnt_reg;
   logic [15:0]        cnt_next;
   tpu_pkg::tpu_dir_t  dir_reg;
   tpu_pkg::tpu_dir_t  dir_next;
   logic [15:0]        mod_reg;
   logic [15:0]        mod_buf_reg;
   logic               modh_seen_reg;
   logic               modl_seen_reg;
   logic [7:0]         div_reg;
   logic [7:0]         rdata_reg;
   logic [7:0]         rd_mux;
   logic [7:0]         ch_rd [NCH];

   wire  wr_tsc   = wr && (addr == tpu_pkg::TSC_ADDR);
   wire  rd_tsc   = rd && (addr == tpu_pkg::TSC_ADDR);
   wire  wr_cnt   = wr && (addr == tpu_pkg::CNTH_ADDR || addr == tpu_pkg::CNTL_ADDR);
   wire  wr_modh  = wr && (addr == tpu_pkg::MODH_ADDR);
   wire  wr_modl  = wr && (addr == tpu_pkg::MODL_ADDR);
   wire  center   = tsc_reg.center_align_select;
   wire  mod_zero = (mod_reg == tpu_pkg::MOD_RESET);

   // prescaler: one-cycle tick every 2**prescale clocks
   wire [7:0] ps_mask = (8'h01 << tsc_reg.prescale) - 8'h01;
   wire       tick    = tsc_reg.run && ((div_reg & ps_mask) == ps_mask);

   // free run to full range with zero modulus
   wire [15:0] term_val = mod_zero ? tpu_pkg::CNT_FULL : mod_reg;
   wire        top_up   = center ? (dir_reg == tpu_pkg::TPU_UP && !mod_zero && cnt_reg == mod_reg)
                                 : (cnt_reg == term_val);
   wire        ovf_ev   = tick && top_up;
   wire        mod_load = modh_seen_reg && modl_seen_reg && (!center || ovf_ev);

   always_comb begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      if (wr_cnt) begin
         cnt_next = tpu_pkg::MOD_RESET;
         dir_next = tpu_pkg::TPU_UP;
      end else if (tick && !center) begin
         dir_next = tpu_pkg::TPU_UP;
         cnt_next = top_up ? tpu_pkg::MOD_RESET : cnt_reg + 16'h0001;
      end else if (tick) begin
         case (dir_reg)
            tpu_pkg::TPU_UP: begin
               if (top_up) begin
                  dir_next = tpu_pkg::TPU_DOWN;
                  cnt_next = cnt_reg - 16'h0001;
               end else begin
                  cnt_next = cnt_reg + 16'h0001;
               end
            end
            tpu_pkg::TPU_DOWN: begin
               if (cnt_reg == tpu_pkg::MOD_RESET) begin
                  dir_next = tpu_pkg::TPU_UP;
                  cnt_next = 16'h0001;
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
               end
            end
            default: dir_next = tpu_pkg::TPU_UP;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= tpu_pkg::MOD_RESET;
         dir_reg <= tpu_pkg::TPU_UP;
         div_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
         div_reg <= tsc_reg.run ? div_reg + 8'h01 : 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tsc_reg <= tpu_pkg::tpu_tsc_t'(tpu_pkg::TSC_RESET);
         tof_reg <= 1'b0;
         tof_arm_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         if (wr_tsc)
            tsc_reg <= tpu_pkg::tpu_tsc_t'({1'b0, wdata[6:0]});
         tof_reg <= flag_upd(tof_reg, tof_arm_reg, ovf_ev, wr_tsc && !wdata[7]);
         tof_arm_reg <= arm_upd(tof_reg, tof_arm_reg, ovf_ev, rd_tsc, wr_tsc);
         irq_reg <= tof_reg && tsc_reg.overflow_irq_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mod_reg <= tpu_pkg::MOD_RESET;
         mod_buf_reg <= tpu_pkg::MOD_RESET;
         modh_seen_reg <= 1'b0;
         modl_seen_reg <= 1'b0;
      end else if (wr_tsc) begin
         modh_seen_reg <= 1'b0;
         modl_seen_reg <= 1'b0;
      end else begin
         if (mod_load) begin
            mod_reg <= mod_buf_reg;
            modh_seen_reg <= 1'b0;
            modl_seen_reg <= 1'b0;
         end
         if (wr_modh) begin
            mod_buf_reg[15:8] <= wdata;
            modh_seen_reg <= 1'b1;
         end
         if (wr_modl) begin
            mod_buf_reg[7:0] <= wdata;
            modl_seen_reg <= 1'b1;
         end
      end
   end

   for (genvar n = 0; n < NCH; n++) begin : g_ch
      localparam logic [7:0] SC_A = 8'(tpu_pkg::CH_BASE + tpu_pkg::CH_STRIDE * n);
      localparam logic [7:0] VH_A = SC_A + tpu_pkg::CH_VH_OFS;
      localparam logic [7:0] VL_A = SC_A + tpu_pkg::CH_VL_OFS;

      tpu_pkg::tpu_chsc_t   sc_reg;
      tpu_pkg::tpu_chmode_t mode;
      logic [15:0]          val_reg;
      logic [15:0]          buf_reg;
      logic                 vh_seen_reg;
      logic                 vl_seen_reg;
      logic                 flag_reg;
      logic                 arm_reg;
      logic                 lvl_reg;
      logic                 lvl_next;
      logic                 pin_reg;
      logic                 oe_n_reg;
      logic                 irq_ch_reg;
      logic                 sync1_reg;
      logic                 sync2_reg;
      logic                 prev_reg;
      logic                 ch_ev;

      wire wr_sc    = wr && (addr == SC_A);
      wire rd_sc    = rd && (addr == SC_A);
      wire wr_vh    = wr && (addr == VH_A);
      wire wr_vl    = wr && (addr == VL_A);
      wire els_a    = sc_reg.edge_level_select_low_bit;
      wire els_b    = sc_reg.edge_level_select_high_bit;

      assign mode = center ? tpu_pkg::TPU_CENTER_PWM :
                    sc_reg.mode_high_bit ? tpu_pkg::TPU_EDGE_PWM :
                    sc_reg.mode_low_bit ? tpu_pkg::TPU_COMPARE : tpu_pkg::TPU_CAPTURE;

      wire is_pwm   = (mode == tpu_pkg::TPU_EDGE_PWM) || (mode == tpu_pkg::TPU_CENTER_PWM);
      wire match    = tick && (cnt_reg == val_reg);
      wire duty_ok  = (val_reg != tpu_pkg::CV_RESET) && !val_reg[15];
      wire rise     = sync2_reg && !prev_reg;
      wire fall     = !sync2_reg && prev_reg;
      wire cap_ev   = (mode == tpu_pkg::TPU_CAPTURE) && ((els_a && rise) || (els_b && fall));
      // pwm waits for the period boundary, others load as soon as both bytes land
      wire v_load   = vh_seen_reg && vl_seen_reg && (!is_pwm || ovf_ev);

      always_comb begin
         case (mode)
            tpu_pkg::TPU_CAPTURE:    ch_ev = cap_ev;
            tpu_pkg::TPU_COMPARE:    ch_ev = match;
            tpu_pkg::TPU_EDGE_PWM:   ch_ev = match;
            tpu_pkg::TPU_CENTER_PWM: ch_ev = match && duty_ok;
            default:                 ch_ev = 1'b0;
         endcase
      end

      always_comb begin
         lvl_next = lvl_reg;
         case (mode)
            tpu_pkg::TPU_CENTER_PWM: begin
               if (!duty_ok)
                  lvl_next = 1'b0;
               else if (!mod_zero && val_reg > mod_reg)
                  lvl_next = 1'b1;
               else if (match)
                  lvl_next = (dir_reg == tpu_pkg::TPU_DOWN);
            end
            tpu_pkg::TPU_EDGE_PWM: begin
               if (val_reg == tpu_pkg::CV_RESET)
                  lvl_next = 1'b0;
               else if (ovf_ev)
                  lvl_next = 1'b1;
               else if (match)
                  lvl_next = 1'b0;
            end
            tpu_pkg::TPU_COMPARE: begin
               if (match)
                  lvl_next = (els_b && els_a) ? 1'b1 : (els_b ? 1'b0 : ~lvl_reg);
            end
            default: lvl_next = lvl_reg;
         endcase
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
         end else begin
            sync1_reg <= ch_pin_in[n];
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            sc_reg <= tpu_pkg::tpu_chsc_t'(tpu_pkg::CHSC_RESET);
            flag_reg <= 1'b0;
            arm_reg <= 1'b0;
            irq_ch_reg <= 1'b0;
         end else begin
            if (wr_sc)
               sc_reg <= tpu_pkg::tpu_chsc_t'({1'b0, wdata[6:2], 2'b00});
            flag_reg <= flag_upd(flag_reg, arm_reg, ch_ev, wr_sc && !wdata[7]);
            arm_reg <= arm_upd(flag_reg, arm_reg, ch_ev, rd_sc, wr_sc);
            irq_ch_reg <= flag_reg && sc_reg.channel_irq_enable;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            val_reg <= tpu_pkg::CV_RESET;
            buf_reg <= tpu_pkg::CV_RESET;
            vh_seen_reg <= 1'b0;
            vl_seen_reg <= 1'b0;
         end else if (wr_sc) begin
            vh_seen_reg <= 1'b0;
            vl_seen_reg <= 1'b0;
         end else begin
            if (cap_ev)
               val_reg <= cnt_reg;
            else if (v_load)
               val_reg <= buf_reg;
            if (v_load) begin
               vh_seen_reg <= 1'b0;
               vl_seen_reg <= 1'b0;
            end
            if (wr_vh) begin
               buf_reg[15:8] <= wdata;
               vh_seen_reg <= 1'b1;
            end
            if (wr_vl) begin
               buf_reg[7:0] <= wdata;
               vl_seen_reg <= 1'b1;
            end
         end
      end

      // pin is released in capture mode and when both select bits are clear
      always_ff @(posedge clk) begin
         if (rst) begin
            lvl_reg <= 1'b0;
            pin_reg <= 1'b0;
            oe_n_reg <= 1'b1;
         end else begin
            lvl_reg <= lvl_next;
            pin_reg <= is_pwm ? (lvl_next ^ els_a) : lvl_next;
            oe_n_reg <= (mode == tpu_pkg::TPU_CAPTURE) || !(els_a || els_b);
         end
      end

      assign ch_pin_out[n]  = pin_reg;
      assign ch_pin_oe_n[n] = oe_n_reg;
      assign channel_irq[n] = irq_ch_reg;
      assign ch_rd[n] = (addr == SC_A) ? {flag_reg, sc_reg[6:0]} :
                        (addr == VH_A) ? val_reg[15:8] :
                        (addr == VL_A) ? val_reg[7:0] : tpu_pkg::RD_IDLE;
   end

   // counter bytes read live; the two-byte read latch is not part of this block
   always_comb begin
      case (addr)
         tpu_pkg::TSC_ADDR:  rd_mux = {tof_reg, tsc_reg[6:0]};
         tpu_pkg::CNTH_ADDR: rd_mux = cnt_reg[15:8];
         tpu_pkg::CNTL_ADDR: rd_mux = cnt_reg[7:0];
         tpu_pkg::MODH_ADDR: rd_mux = mod_reg[15:8];
         tpu_pkg::MODL_ADDR: rd_mux = mod_reg[7:0];
         default: begin
            rd_mux = tpu_pkg::RD_IDLE;
            for (int i = 0; i < NCH; i++)
               rd_mux = rd_mux | ch_rd[i];
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst)
         rdata_reg <= tpu_pkg::RD_IDLE;
      else
         rdata_reg <= rd ? rd_mux : tpu_pkg::RD_IDLE;
   end

   assign rdata        = rdata_reg;
   assign overflow_irq = irq_reg;

endmodule : tpu_timer

`default_nettype wire
